// File: rtl/ccs_sequencer.sv
// Implementation choice: the address-and-strobe port.
`default_nettype none
module ccs_sequencer #(
	parameter int unsigned LP_STEP_CYCLES =
		ccs_pkg::LP_DELAY_STEP_MS * ccs_pkg::CYCLES_PER_MS,
	parameter int unsigned TOUCH_CYCLES =
		ccs_pkg::TOUCH_PERIOD_MS * ccs_pkg::CYCLES_PER_MS
) (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic [ccs_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [ccs_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                        regWrite,
	input  wire logic                        regRead,
	output logic      [ccs_pkg::DATA_W-1:0]  regRdData,
	input  wire logic [15:0]                 modSample,
	output logic                             modSampleStrobe,
	output logic      [ccs_pkg::PINS-1:0]    pinToNeg,
	output logic      [ccs_pkg::PINS-1:0]    pinToPos,
	output logic      [ccs_pkg::PINS-1:0]    pinToGuard,
	output logic      [ccs_pkg::TRIM_W-1:0]  plusTrim,
	output logic                             plusToNegInput,
	output logic      [ccs_pkg::TRIM_W-1:0]  minusTrim,
	output logic                             minusToPosInput,
	output logic      [3:0]                  stageActive,
	output logic                             converting,
	output logic                             resultValid,
	output logic      [15:0]                 resultData,
	output logic      [3:0]                  resultStage,
	output logic                             ffEnter,
	output logic      [15:0]                 ffData,
	output logic      [ccs_pkg::STAGES-1:0]  buttonUp,
	output logic      [ccs_pkg::STAGES-1:0]  buttonDown
);
	import ccs_pkg::*;

	logic [1:0]          modeR;
	logic [1:0]          delayR;
	logic [1:0]          decR;
	logic [3:0]          lastCfgR;
	logic [3:0]          skipR;
	logic [STAGES-1:0]   calEnR;
	logic [15:0]         thrHighR;
	logic [15:0]         thrLowR;
	logic [ROUTE_W-1:0]  routeMem [STAGES];
	logic [15:0]         trimMem [STAGES];
	logic [15:0]         resultMem [STAGES];

	ccs_state_t          state_r;
	logic [3:0]          stage_r;
	logic [3:0]          seqCnt_r;
	logic                decStart_r;
	logic [31:0]         waitCnt_r;
	logic [31:0]         elapsed_r;
	logic [9:0]          divCnt_r;
	logic [ROUTE_W-1:0]  pinSel_r;

	logic                shutdown;
	logic                lowPower;
	logic [3:0]          lastStage;
	logic                touched;
	logic [31:0]         delayCycles;
	logic                decDone;
	logic [15:0]         decAvg;
	logic [ROUTE_W-1:0]  curRoute;
	logic [15:0]         curTrim;
	logic                wakeNow;
	logic                routeHit;
	logic                trimHit;
	logic                resHit;
	logic [3:0]          rdIdx;

	assign shutdown = modeR[0];
	assign lowPower = (modeR == MODE_LOW);
	// out-of-range last stage clamps to twelve stages
	assign lastStage = (lastCfgR > LAST_STAGE_MAX) ? LAST_STAGE_MAX : lastCfgR;
	assign touched = (|buttonUp) | (|buttonDown);
	// delay is (code + 1) steps of 100 ms
	assign delayCycles = 32'(({30'h0, delayR} + 32'h1) * LP_STEP_CYCLES);
	assign curRoute = routeMem[stage_r];
	assign curTrim = trimMem[stage_r];
	assign routeHit = (regAddr[9:5] == ADR_ROUTE_PAGE)
		&& (regAddr[4:1] <= LAST_STAGE_MAX);
	assign trimHit = (regAddr[9:4] == ADR_TRIM_PAGE)
		&& (regAddr[3:0] <= LAST_STAGE_MAX);
	assign resHit = (regAddr[9:4] == ADR_RES_PAGE)
		&& (regAddr[3:0] <= LAST_STAGE_MAX);
	assign rdIdx = regAddr[3:0];

	always_ff @(posedge clock) begin
		if (rst) begin
			divCnt_r <= 10'h000;
			modSampleStrobe <= 1'b0;
		end else begin
			modSampleStrobe <= (divCnt_r == MOD_DIV_LAST);
			divCnt_r <= (divCnt_r == MOD_DIV_LAST) ? 10'h000
				: divCnt_r + 10'h001;
		end
	end

	// mode, delay and decimation fields, reset to full power
	always_ff @(posedge clock) begin
		if (rst) begin
			modeR <= MODE_FULL;
			delayR <= 2'h0;
			decR <= DEC_256;
			lastCfgR <= 4'h0;
			skipR <= 4'h0;
			calEnR <= '0;
			thrHighR <= 16'hFFFF;
			thrLowR <= 16'h0000;
		end else if (regWrite) begin
			case (regAddr)
				ADR_CONTROL: begin
					modeR <= regWrData[CTL_MODE_LSB +: 2];
					delayR <= regWrData[CTL_DELAY_LSB +: 2];
					decR <= regWrData[CTL_DEC_LSB +: 2];
				end
				ADR_SEQ_CFG: begin
					lastCfgR <= regWrData[SEQ_LAST_LSB +: 4];
					skipR <= regWrData[SEQ_SKIP_LSB +: 4];
				end
				ADR_CAL_EN: calEnR <= regWrData[STAGES-1:0];
				ADR_THR_HIGH: thrHighR <= regWrData;
				ADR_THR_LOW: thrLowR <= regWrData;
				default: ;
			endcase
		end
	end

	// two-bit field per pin, two words per stage
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int s = 0; s < STAGES; s++) begin
				routeMem[s] <= '0;
				trimMem[s] <= 16'h0000;
			end
		end else if (regWrite) begin
			if (routeHit && !regAddr[0])
				routeMem[regAddr[4:1]][15:0] <= regWrData;
			if (routeHit && regAddr[0])
				routeMem[regAddr[4:1]][ROUTE_W-1:16] <= regWrData[ROUTE_W-17:0];
			if (trimHit)
				trimMem[regAddr[3:0]] <= regWrData;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			regRdData <= 16'h0000;
		end else if (regRead) begin
			regRdData <= 16'h0000;
			if (routeHit && !regAddr[0])
				regRdData <= routeMem[regAddr[4:1]][15:0];
			else if (routeHit)
				regRdData <= {4'h0, routeMem[regAddr[4:1]][ROUTE_W-1:16]};
			else if (trimHit)
				regRdData <= trimMem[rdIdx];
			else if (resHit)
				regRdData <= resultMem[rdIdx];
			else begin
				case (regAddr)
					ADR_CONTROL: regRdData <= {6'h00, decR, 4'h0, delayR, modeR};
					ADR_SEQ_CFG: regRdData <= {8'h00, skipR, lastCfgR};
					ADR_CAL_EN: regRdData <= {4'h0, calEnR};
					ADR_STATUS: regRdData <= {8'h00, touched, state_r[3],
						state_r[0], converting, stage_r};
					ADR_BTN_UP: regRdData <= {4'h0, buttonUp};
					ADR_BTN_DOWN: regRdData <= {4'h0, buttonDown};
					ADR_THR_HIGH: regRdData <= thrHighR;
					ADR_THR_LOW: regRdData <= thrLowR;
					default: regRdData <= 16'h0000;
				endcase
			end
		end else begin
			regRdData <= 16'h0000;
		end
	end

	// touched wakes 40 ms after the last measurement began
	// idle wake after measurement plus delay
	assign wakeNow = touched ? (elapsed_r >= 32'(TOUCH_CYCLES - 1))
		: (waitCnt_r >= delayCycles - 32'h1);

	// stages run in order from the sequence start
	always_ff @(posedge clock) begin
		decStart_r <= 1'b0;
		if (rst) begin
			state_r <= S_IDLE;
			stage_r <= 4'h0;
			seqCnt_r <= 4'h0;
			waitCnt_r <= 32'h0;
			elapsed_r <= 32'h0;
		end else begin
			case (state_r)
				S_OFF: begin
					if (!shutdown)
						state_r <= S_IDLE;
				end
				S_IDLE: begin
					if (shutdown) begin
						state_r <= S_OFF;
					end else begin
						state_r <= S_CONV;
						stage_r <= 4'h0;
						seqCnt_r <= 4'h0;
						elapsed_r <= 32'h0;
						decStart_r <= 1'b1;
					end
				end
				S_CONV: begin
					elapsed_r <= elapsed_r + 32'h1;
					if (shutdown) begin
						state_r <= S_OFF;
					end else if (decDone) begin
						// stop at the programmed last stage
						if (stage_r < lastStage) begin
							stage_r <= stage_r + 4'h1;
							decStart_r <= 1'b1;
						end else begin
							stage_r <= 4'h0;
							if (seqCnt_r >= skipR) begin
								seqCnt_r <= 4'h0;
								if (lowPower) begin
									state_r <= S_SLEEP;
									waitCnt_r <= 32'h0;
								end else begin
									elapsed_r <= 32'h0;
									decStart_r <= 1'b1;
								end
							end else begin
								seqCnt_r <= seqCnt_r + 4'h1;
								decStart_r <= 1'b1;
							end
						end
					end
				end
				S_SLEEP: begin
					elapsed_r <= elapsed_r + 32'h1;
					waitCnt_r <= waitCnt_r + 32'h1;
					if (shutdown) begin
						state_r <= S_OFF;
					end else if (!lowPower || wakeNow) begin
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	ccs_decimator u_decimator (
		.clock   (clock),
		.rst     (rst),
		.start   (decStart_r),
		.tick    (modSampleStrobe),
		.decCode (decR),
		.sample  (modSample),
		.done    (decDone),
		.average (decAvg)
	);

	// apply the converting stage's routing, float otherwise
	always_ff @(posedge clock) begin
		if (rst) begin
			pinSel_r <= '0;
			converting <= 1'b0;
			stageActive <= 4'h0;
		end else begin
			pinSel_r <= (state_r == S_CONV) ? curRoute : '0;
			converting <= (state_r == S_CONV);
			stageActive <= stage_r;
		end
	end

	// negative, positive, guard or floating per pin
	for (genvar p = 0; p < PINS; p++) begin : g_pin
		assign pinToNeg[p] = (pinSel_r[2*p +: 2] == ROUTE_NEG);
		assign pinToPos[p] = (pinSel_r[2*p +: 2] == ROUTE_POS);
		assign pinToGuard[p] = (pinSel_r[2*p +: 2] == ROUTE_GUARD);
	end

	// per-stage trims with input swap bits
	always_ff @(posedge clock) begin
		if (rst) begin
			plusTrim <= '0;
			plusToNegInput <= 1'b0;
			minusTrim <= '0;
			minusToPosInput <= 1'b0;
		end else begin
			plusTrim <= curTrim[TRIM_PLUS_LSB +: TRIM_W];
			plusToNegInput <= curTrim[TRIM_PLUS_SW];
			minusTrim <= curTrim[TRIM_MINUS_LSB +: TRIM_W];
			minusToPosInput <= curTrim[TRIM_MINUS_SW];
		end
	end

	// one result in skip+1 sequences enters the fast filter
	always_ff @(posedge clock) begin
		if (rst) begin
			resultValid <= 1'b0;
			resultData <= 16'h0000;
			resultStage <= 4'h0;
			ffEnter <= 1'b0;
			ffData <= 16'h0000;
			buttonUp <= '0;
			buttonDown <= '0;
			for (int s = 0; s < STAGES; s++)
				resultMem[s] <= 16'h0000;
		end else begin
			resultValid <= decDone && (state_r == S_CONV);
			ffEnter <= decDone && (state_r == S_CONV) && (seqCnt_r == 4'h0);
			if (decDone && state_r == S_CONV) begin
				resultData <= decAvg;
				resultStage <= stage_r;
				resultMem[stage_r] <= decAvg;
				if (seqCnt_r == 4'h0)
					ffData <= decAvg;
				// crossing both limits reports neither button
				buttonUp[stage_r] <= (decAvg > thrHighR) && !(decAvg < thrLowR);
				buttonDown[stage_r] <= (decAvg < thrLowR) && !(decAvg > thrHighR);
			end
		end
	end

	a_route_apply: assert property (@(posedge clock) disable iff (rst)
		$past(state_r == S_CONV) |-> pinSel_r == $past(curRoute))
		else $error("pin routing not taken from current stage");
	a_float_idle: assert property (@(posedge clock) disable iff (rst)
		!converting |-> (pinToNeg == '0 && pinToPos == '0 && pinToGuard == '0))
		else $error("pin connected while not converting");
	a_stage_bound: assert property (@(posedge clock) disable iff (rst)
		(state_r == S_CONV) |-> stage_r <= lastStage)
		else $error("stage beyond programmed last stage");
	a_full_wrap: assert property (@(posedge clock) disable iff (rst)
		(state_r == S_CONV && decDone && !shutdown && !lowPower
			&& stage_r == lastStage && seqCnt_r >= skipR)
		|=> (state_r == S_CONV && stage_r == 4'h0 && decStart_r))
		else $error("full power sequence did not restart at stage zero");
	a_shut_off: assert property (@(posedge clock) disable iff (rst)
		shutdown [*2] |-> state_r == S_OFF)
		else $error("shutdown mode not honoured");
	a_mod_tick: assert property (@(posedge clock) disable iff (rst)
		modSampleStrobe |=> !modSampleStrobe [*8])
		else $error("modulator strobe too frequent");
	a_pair_excl: assert property (@(posedge clock) disable iff (rst)
		(buttonUp & buttonDown) == '0)
		else $error("both buttons of a pair reported");
	a_lp_wake: assert property (@(posedge clock) disable iff (rst)
		(state_r == S_SLEEP && lowPower && !shutdown && !touched
			&& waitCnt_r >= delayCycles - 32'h1) |=> state_r == S_IDLE ##1
		state_r == S_CONV)
		else $error("low power wake missed after delay");
	a_ff_drop: assert property (@(posedge clock) disable iff (rst)
		ffEnter |-> ($past(seqCnt_r) == 4'h0 && resultValid))
		else $error("skipped result entered fast filter");
endmodule
`default_nettype wire

// File: rtl/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int PINS = 14;
	localparam int STAGES = 12;
	localparam int ROUTE_W = 2 * PINS;
	localparam int TRIM_W = 7;

	localparam logic [9:0] ADR_CONTROL    = 10'h000;
	localparam logic [9:0] ADR_SEQ_CFG    = 10'h001;
	localparam logic [9:0] ADR_CAL_EN     = 10'h002;
	localparam logic [9:0] ADR_STATUS     = 10'h003;
	localparam logic [9:0] ADR_BTN_UP     = 10'h004;
	localparam logic [9:0] ADR_THR_HIGH   = 10'h005;
	localparam logic [9:0] ADR_THR_LOW    = 10'h006;
	localparam logic [9:0] ADR_BTN_DOWN   = 10'h007;
	localparam logic [4:0] ADR_ROUTE_PAGE = 5'h02;
	localparam logic [5:0] ADR_TRIM_PAGE  = 6'h06;
	localparam logic [5:0] ADR_RES_PAGE   = 6'h07;

	localparam int CTL_MODE_LSB  = 0;
	localparam int CTL_DELAY_LSB = 2;
	localparam int CTL_DEC_LSB   = 8;
	localparam int SEQ_LAST_LSB  = 0;
	localparam int SEQ_SKIP_LSB  = 4;
	localparam int TRIM_PLUS_LSB = 0;
	localparam int TRIM_PLUS_SW  = 7;
	localparam int TRIM_MINUS_LSB = 8;
	localparam int TRIM_MINUS_SW = 15;

	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_LOW  = 2'h2;
	localparam logic [1:0] DEC_256   = 2'h0;
	localparam logic [1:0] DEC_128   = 2'h1;
	localparam logic [7:0] DEC_LAST_256 = 8'hFF;
	localparam logic [7:0] DEC_LAST_128 = 8'h7F;
	localparam logic [7:0] DEC_LAST_64  = 8'h3F;
	localparam logic [3:0] DEC_SHIFT_256 = 4'h8;
	localparam logic [3:0] DEC_SHIFT_128 = 4'h7;
	localparam logic [3:0] DEC_SHIFT_64  = 4'h6;

	localparam logic [1:0] ROUTE_FLOAT = 2'h0;
	localparam logic [1:0] ROUTE_NEG   = 2'h1;
	localparam logic [1:0] ROUTE_POS   = 2'h2;
	localparam logic [1:0] ROUTE_GUARD = 2'h3;
	localparam logic [3:0] LAST_STAGE_MAX = 4'hB;

	localparam int CLK_HZ = 200_000_000;
	localparam int MOD_HZ = 240_000;
	localparam int MOD_DIV = CLK_HZ / MOD_HZ;
	localparam logic [9:0] MOD_DIV_LAST = 10'(MOD_DIV - 1);
	localparam int CYCLES_PER_MS = CLK_HZ / 1000;
	localparam int LP_DELAY_STEP_MS = 100;
	localparam int TOUCH_PERIOD_MS = 40;

	typedef enum logic [3:0] {
		S_OFF   = 4'h1,
		S_IDLE  = 4'h2,
		S_CONV  = 4'h4,
		S_SLEEP = 4'h8
	} ccs_state_t;

	function automatic logic [7:0] ccs_dec_last(input logic [1:0] code);
		case (code)
			DEC_256: return DEC_LAST_256;
			DEC_128: return DEC_LAST_128;
			default: return DEC_LAST_64;
		endcase
	endfunction

	function automatic logic [3:0] ccs_dec_shift(input logic [1:0] code);
		case (code)
			DEC_256: return DEC_SHIFT_256;
			DEC_128: return DEC_SHIFT_128;
			default: return DEC_SHIFT_64;
		endcase
	endfunction
endpackage
`default_nettype wire

// File: rtl/ccs_decimator.sv
`default_nettype none
module ccs_decimator (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   start,
	input  wire logic                   tick,
	input  wire logic [1:0]             decCode,
	input  wire logic [15:0]            sample,
	output logic                        done,
	output logic [15:0]                 average
);
	import ccs_pkg::*;

	logic        run_r;
	logic [7:0]  cnt_r;
	logic [7:0]  last_r;
	logic [3:0]  shift_r;
	logic [23:0] acc_r;
	logic [23:0] sum;
	logic [23:0] scaled;

	assign sum = acc_r + {8'h00, sample};
	assign scaled = sum >> shift_r;

	always_ff @(posedge clock) begin
		done <= 1'b0;
		if (rst) begin
			run_r <= 1'b0;
			cnt_r <= 8'h00;
			last_r <= DEC_LAST_64;
			shift_r <= DEC_SHIFT_64;
			acc_r <= 24'h000000;
			average <= 16'h0000;
		end else if (start) begin
			// ratio latched so a mid-stage write cannot skew one result
			run_r <= 1'b1;
			cnt_r <= 8'h00;
			last_r <= ccs_dec_last(decCode);
			shift_r <= ccs_dec_shift(decCode);
			acc_r <= 24'h000000;
		end else if (run_r && tick) begin
			acc_r <= sum;
			cnt_r <= cnt_r + 8'h01;
			if (cnt_r == last_r) begin
				run_r <= 1'b0;
				done <= 1'b1;
				average <= scaled[15:0];
			end
		end
	end

	a_avg_count: assert property (@(posedge clock) disable iff (rst)
		(run_r && tick && !start && cnt_r == last_r) |=> done)
		else $error("decimator missed end of ratio");
	a_avg_early: assert property (@(posedge clock) disable iff (rst)
		done |-> $past(cnt_r) == last_r)
		else $error("decimator finished before ratio count");
endmodule
`default_nettype wire

// File: tb/ccs_front_model.sv
`default_nettype none
module ccs_front_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        modSampleStrobe,
	input  wire logic [13:0] pinToPos,
	input  wire logic [13:0] pinToNeg,
	output logic      [15:0] modSample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        phase_r;
	logic [15:0] level;
	always_ff @(posedge clock) begin
		if (rst) begin
			phase_r <= 1'b0;
		end else if (modSampleStrobe) begin
			phase_r <= ~phase_r;
		end
	end
	// routed pins shape level
	// alternating offset so only a true average lands on level plus one
	assign level = {pinToPos[7:0], pinToNeg[7:0]} + {14'h0, phase_r, 1'b0};
	// valid only on strobe
	// off-strobe the inverse, so a late or early pick shows up
	assign modSample = modSampleStrobe ? level : ~level;
endmodule
`default_nettype wire

// File: tb/tb_capacitance_conversion_sequencer.sv
`default_nettype none
module tb_capacitance_conversion_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import ccs_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [9:0]  regAddr = 10'h000;
	logic [15:0] regWrData = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [15:0] regRdData;
	logic [15:0] modSample;
	logic        modSampleStrobe;
	logic [13:0] pinToNeg;
	logic [13:0] pinToPos;
	logic [13:0] pinToGuard;
	logic [6:0]  plusTrim;
	logic        plusToNegInput;
	logic [6:0]  minusTrim;
	logic        minusToPosInput;
	logic [3:0]  stageActive;
	logic        converting;
	logic        resultValid;
	logic [15:0] resultData;
	logic [3:0]  resultStage;
	logic        ffEnter;
	logic [15:0] ffData;
	logic [11:0] buttonUp;
	logic [11:0] buttonDown;
	int          nMismatch = 0;
	int          checksDone = 0;
	int          cycles = 0;

	always #2.5 clock = ~clock;

	ccs_sequencer #(.LP_STEP_CYCLES(200), .TOUCH_CYCLES(100)) dut (
		.clock(clock), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .modSample(modSample),
		.modSampleStrobe(modSampleStrobe), .pinToNeg(pinToNeg),
		.pinToPos(pinToPos), .pinToGuard(pinToGuard),
		.plusTrim(plusTrim), .plusToNegInput(plusToNegInput),
		.minusTrim(minusTrim), .minusToPosInput(minusToPosInput),
		.stageActive(stageActive), .converting(converting),
		.resultValid(resultValid), .resultData(resultData),
		.resultStage(resultStage), .ffEnter(ffEnter), .ffData(ffData),
		.buttonUp(buttonUp), .buttonDown(buttonDown)
	);

	ccs_front_model front (
		.clock(clock), .rst(rst), .modSampleStrobe(modSampleStrobe),
		.pinToPos(pinToPos), .pinToNeg(pinToNeg), .modSample(modSample)
	);

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// two conversions of 64 ticks (about 107k cycles) plus small margin
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 115000) begin
			nMismatch = nMismatch + 1;
			$display("mismatch at %0t: run hung", $time);
			giveVerdict();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone = checksDone + 1;
		if (seen !== exp) begin
			nMismatch = nMismatch + 1;
			$display("mismatch at %0t: seen %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [15:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk(regRdData, exp);
	endtask

	task automatic wait_result(output int elapsed);
		elapsed = 0;
		do begin
			@(posedge clock);
			#1;
			elapsed++;
		end while (resultValid !== 1'b1);
	endtask

	task automatic test_power_on();
		repeat (3) @(posedge clock);
		#1;
		chk(16'(converting), 16'h0001);
		chk(16'(stageActive), 16'h0000);
		wr(ADR_CONTROL, 16'h0001);
		repeat (2) @(posedge clock);
		#1;
		chk(16'(converting), 16'h0000);
		rd(ADR_STATUS, 16'h0020);
		rd(ADR_THR_HIGH, 16'hFFFF);
		rd(ADR_SEQ_CFG, 16'h0000);
		rd(ADR_CONTROL, 16'h0001);
		wr(10'h3FF, 16'h1234);
		rd(10'h3FF, 16'h0000);
	endtask

	task automatic test_config();
		wr(ADR_CONTROL, 16'h0301);
		// sim-length measurement; silicon config targets 35-40 ms
		wr(ADR_SEQ_CFG, 16'h0001);
		// unused pins on guard, enables match the two stages
		wr(ADR_CAL_EN, 16'h0003);
		wr(10'h040, 16'hFFF6);
		wr(10'h041, 16'h0FFF);
		wr(10'h042, 16'hFF6F);
		wr(10'h043, 16'h0FFF);
		wr(10'h060, 16'h8305);
		wr(ADR_THR_HIGH, 16'h0200);
		wr(ADR_THR_LOW, 16'h0100);
		rd(10'h040, 16'hFFF6);
		rd(ADR_CONTROL, 16'h0301);
		wr(ADR_CONTROL, 16'h0300);
	endtask

	task automatic test_first_step();
		int gap;
		int elapsed;
		repeat (6) @(posedge clock);
		#1;
		chk(16'(pinToPos), 16'h0001);
		chk(16'(pinToNeg), 16'h0002);
		chk(16'(pinToGuard), 16'h3FFC);
		chk(16'(plusTrim), 16'h0005);
		chk(16'(minusTrim), 16'h0003);
		chk(16'(plusToNegInput), 16'h0000);
		chk(16'(minusToPosInput), 16'h0001);
		while (modSampleStrobe !== 1'b1) begin
			@(posedge clock);
			#1;
		end
		gap = 0;
		do begin
			@(posedge clock);
			#1;
			gap++;
		end while (modSampleStrobe !== 1'b1 && gap < 2000);
		chk(16'(gap), 16'(MOD_DIV));
		wait_result(elapsed);
		chk(resultData, 16'h0103);
		chk(16'(ffEnter), 16'h0001);
		chk(ffData, 16'h0103);
		chk(16'(resultStage), 16'h0000);
		// whole stage at 64 ticks, code 11 picks 64
		chk(16'(elapsed > 62 * MOD_DIV && elapsed < 64 * MOD_DIV), 16'h0001);
		repeat (3) @(posedge clock);
		#1;
		chk(16'(stageActive), 16'h0001);
		chk(16'(pinToPos), 16'h0004);
		chk(16'(pinToNeg), 16'h0008);
		chk(16'(pinToGuard), 16'h3FF3);
	endtask

	task automatic test_stage1_wrap();
		int elapsed;
		wait_result(elapsed);
		chk(resultData, 16'h0409);
		chk(16'(resultStage), 16'h0001);
		chk(16'(elapsed > 63 * MOD_DIV && elapsed < 65 * MOD_DIV), 16'h0001);
		repeat (3) @(posedge clock);
		#1;
		chk(16'(stageActive), 16'h0000);
		chk(16'(converting), 16'h0001);
		chk(16'(buttonUp), 16'h0002);
		chk(16'(buttonDown), 16'h0000);
		rd(10'h070, 16'h0103);
		rd(10'h071, 16'h0409);
		rd(ADR_BTN_UP, 16'h0002);
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		test_power_on();
		test_config();
		test_first_step();
		test_stage1_wrap();
		giveVerdict();
	end
endmodule
`default_nettype wire
